// ===== hdl/qwm_pkg.sv
// Shared constants and types of the byte-lane masked burst write link.
// Assumes one 25 MHz clock at both ends and a link carried by qwm_link_if.
// Summary of operation
// - x8: two nibble selects gate bits 3:0, 7:4
// - x8: both nibble selects low store all
// - x18: selects gate bits 8:0 and 17:9
// - x18: both selects low store eighteen bits
// - x9: one select stores nine bits or nothing
// - x36: four selects gate four nine-bit lanes
// - x36: all four selects low store all
// - All selects high: beat stores nothing
// - Selects evaluated per beat on its edge
// - Selects may change beat to beat
// - Beats alternate positive and negative clock rises
// - No write start on consecutive rises; ignore
// - Beats go to A, A+1, A+2, A+3
package qwm_pkg;
    // Clock and link timing.
    localparam int CLK_PERIOD_NS = 40;
    localparam int K_PERIOD_NS   = 320;
    localparam int K_PERIOD_CYC  = K_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PH_W          = $clog2(K_PERIOD_CYC);
    localparam logic [PH_W-1:0] PH_PREP_K  = PH_W'(K_PERIOD_CYC - 2);
    localparam logic [PH_W-1:0] PH_PREP_KN = PH_W'(K_PERIOD_CYC / 2 - 2);
    // Burst shape.
    localparam int BURST_LEN = 4;
    localparam int BEAT_W    = 2;
    // Organisations: lane count and lane width.
    localparam int NIBBLE_W  = 4;
    localparam int BYTE_W    = 9;
    localparam int X8_LANES  = 2;
    localparam int X9_LANES  = 1;
    localparam int X18_LANES = 2;
    localparam int X36_LANES = 4;
    // Array depth in address bits and buffer depth.
    localparam int ADDR_W     = 6;
    localparam int FIFO_DEPTH = 16;
    // Reset values of link levels.
    localparam logic RST_CLK_LEVEL = 1'b0;
    localparam logic RST_START_N   = 1'b1;
    // Controller sequencing.
    typedef enum logic [1:0] {CTL_IDLE, CTL_ADDR, CTL_BEAT} qwm_ctl_state_t;
    // Device data phase.
    typedef enum logic {DEV_IDLE, DEV_BURST} qwm_dev_state_t;
endpackage

// ===== hdl/qwm_link_if.sv
// Link between the burst write controller and the masked write device.
// Assumes both ends share clk_i; k and kn are levels the device samples.
interface qwm_link_if #(
    parameter int LANES  = qwm_pkg::X36_LANES,
    parameter int LANE_W = qwm_pkg::BYTE_W,
    parameter int ADDR_W = qwm_pkg::ADDR_W
);
    // Positive and negative input clocks, as levels.
    logic                    k;
    logic                    kn;
    // Write port select, low starts a write burst on a k rise.
    logic                    start_n;
    logic [ADDR_W-1:0]       addr;
    // Bit i is lane i write select, active low (lane0..lane3, or
    // low and high nibble in the eight-bit organisation).
    logic [LANES-1:0]        lane_write_select_n;
    logic [LANES*LANE_W-1:0] data;

    // Controller end drives everything.
    modport ctrl (output k, output kn, output start_n, output addr,
                  output lane_write_select_n, output data);
    // Device end only listens.
    modport dev (input k, input kn, input start_n, input addr,
                 input lane_write_select_n, input data);
endinterface

// ===== hdl/qwm_device.sv
// Masked burst write device end: capture, lane masking and array.
// Assumes link pins come from outside the clock domain and are
// held stable by the far end around each clock rise.
module qwm_device #(
    parameter int LANES  = qwm_pkg::X36_LANES,
    parameter int LANE_W = qwm_pkg::BYTE_W,
    parameter int ADDR_W = qwm_pkg::ADDR_W
) (
    // Clock and reset.
    input  wire logic                    clk_i,
    input  wire logic                    resetn_i,
    // Link from the controller.
    qwm_link_if.dev                      link,
    // Inspection read of the array.
    input  wire logic [ADDR_W-1:0]       rd_addr_i,
    output logic      [LANES*LANE_W-1:0] rd_data_o,
    // Report of each stored beat.
    output logic                         wr_strobe_o,
    output logic      [ADDR_W-1:0]       wr_addr_o,
    output logic      [LANES-1:0]        wr_lane_en_o,
    output logic      [LANES*LANE_W-1:0] wr_data_o,
    // Pulse when a write start was refused.
    output logic                         ignored_o
);
    localparam int DW    = LANES * LANE_W;
    localparam int SW    = 3 + ADDR_W + LANES + DW;
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [SW-1:0] SYNC_RST = {qwm_pkg::RST_CLK_LEVEL,
        qwm_pkg::RST_CLK_LEVEL, qwm_pkg::RST_START_N,
        {ADDR_W{1'b0}}, {LANES{1'b1}}, {DW{1'b0}}};
    localparam logic [qwm_pkg::BEAT_W-1:0] LAST_BEAT =
        qwm_pkg::BEAT_W'(qwm_pkg::BURST_LEN - 1);

    logic [SW-1:0]                 sync1;
    logic [SW-1:0]                 sync2;
    logic                          s_k;
    logic                          s_kn;
    logic                          s_start_n;
    logic [ADDR_W-1:0]             s_addr;
    logic [LANES-1:0]              s_sel_n;
    logic [DW-1:0]                 s_data;
    logic                          k_prev;
    logic                          kn_prev;
    logic                          k_rise;
    logic                          kn_rise;
    logic                          pend;
    logic [ADDR_W-1:0]             pend_addr;
    qwm_pkg::qwm_dev_state_t       state;
    logic [qwm_pkg::BEAT_W-1:0]    beat;
    logic [ADDR_W-1:0]             base;
    logic                          accept;
    logic                          refuse;
    logic                          first_take;
    logic                          later_take;
    logic                          beat_take;
    logic [ADDR_W-1:0]             beat_addr;
    logic [LANES-1:0]              lane_en;
    logic [LANES-1:0][LANE_W-1:0]  lane_rd;

    // Every link pin passes two flops; the whole bundle moves together
    // so a beat's data and selects stay aligned with its clock edge.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1 <= SYNC_RST;
            sync2 <= SYNC_RST;
        end else begin
            sync1 <= {link.k, link.kn, link.start_n, link.addr,
                      link.lane_write_select_n, link.data};
            sync2 <= sync1;
        end
    end

    // Unpack the synchronised bundle.
    assign {s_k, s_kn, s_start_n, s_addr, s_sel_n, s_data} = sync2;

    // Edge history of both input clocks.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            k_prev  <= qwm_pkg::RST_CLK_LEVEL;
            kn_prev <= qwm_pkg::RST_CLK_LEVEL;
        end else begin
            k_prev  <= s_k;
            kn_prev <= s_kn;
        end
    end

    // Only rising edges matter; the device never uses falling edges.
    assign k_rise  = s_k & ~k_prev;
    assign kn_rise = s_kn & ~kn_prev;

    // A start on the rise right after an accepted start is dropped.
    assign accept = k_rise & ~s_start_n & ~pend;
    assign refuse = k_rise & ~s_start_n & pend;

    // Beat 0 and 2 land on k rises, beats 1 and 3 on kn rises.
    assign first_take = k_rise & pend;
    assign later_take = (state == qwm_pkg::DEV_BURST) &
                        ((k_rise & (beat == 2'h2)) |
                         (kn_rise & beat[0]));
    assign beat_take  = first_take | later_take;

    // Burst addresses step from the latched one and wrap in the array.
    assign beat_addr = first_take ? pend_addr :
                       ADDR_W'(base + ADDR_W'(beat));

    // Each beat uses its own selects, sampled with its own edge, and
    // only during the data phase; all high stores nothing.
    assign lane_en = {LANES{beat_take}} & ~s_sel_n;

    // Address phase: hold an accepted start until its first data rise.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend      <= 1'b0;
            pend_addr <= '0;
        end else if (accept) begin
            pend      <= 1'b1;
            pend_addr <= s_addr;
        end else if (k_rise) begin
            pend      <= 1'b0;
        end
    end

    // Data phase: count the four beats of the running burst.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= qwm_pkg::DEV_IDLE;
            beat  <= '0;
            base  <= '0;
        end else if (first_take) begin
            state <= qwm_pkg::DEV_BURST;
            base  <= pend_addr;
            beat  <= 2'h1;
        end else if (later_take) begin
            beat <= beat + 2'h1;
            case (beat)
                LAST_BEAT: state <= qwm_pkg::DEV_IDLE;
                default:   state <= qwm_pkg::DEV_BURST;
            endcase
        end
    end

    // One storage column per lane; an unselected lane keeps its word.
    // Lane i covers data bits [i*LANE_W +: LANE_W], which gives 3:0 and
    // 7:4 for nibbles and 8:0, 17:9, 26:18, 35:27 for nine-bit lanes.
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [LANE_W-1:0] mem [DEPTH];

        // Lane write, gated by its own enable only.
        always_ff @(posedge clk_i) begin
            if (lane_en[i]) begin
                mem[beat_addr] <= s_data[i*LANE_W +: LANE_W];
            end
        end

        // Inspection read of this lane.
        assign lane_rd[i] = mem[rd_addr_i];
    end

    // All enables high together store the full word in one beat; this
    // falls out of the per-lane columns with no special case.

    // Registered inspection read; the array itself has no reset, so a
    // location reads unknown until first written.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= lane_rd;
        end
    end

    // Report every captured beat, even one that stores no lane.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_strobe_o  <= 1'b0;
            wr_addr_o    <= '0;
            wr_lane_en_o <= '0;
            wr_data_o    <= '0;
        end else begin
            wr_strobe_o  <= beat_take;
            wr_addr_o    <= beat_addr;
            wr_lane_en_o <= lane_en;
            wr_data_o    <= s_data;
        end
    end

    // Refused start indication.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ignored_o <= 1'b0;
        end else begin
            ignored_o <= refuse;
        end
    end
endmodule // qwm_device

// ===== hdl/qwm_ctrl.sv
// Controller end: a beat buffer and the burst write sequencer.
// Assumes the device samples the link through two flops on clk_i.

// Flip-flop FIFO with registered flags and a fill level.
module qwm_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = qwm_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic                       clk_i,
    input  wire logic                       resetn_i,
    // Fill side.
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    input  wire logic [W-1:0]               in_data_i,
    // Drain side.
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic      [W-1:0]               out_data_o,
    output logic      [$clog2(DEPTH+1)-1:0] level_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic          push;
    logic          pop;
    logic [CW-1:0] next_level;

    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_ptr];
    assign next_level = CW'(level_o + CW'(push) - CW'(pop));

    // Storage write.
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
            end
        end
    end

    // Level and flags are registered so the ports come from flops.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            level_o     <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            level_o     <= next_level;
            in_ready_o  <= next_level != CW'(DEPTH);
            out_valid_o <= next_level != '0;
        end
    end
endmodule // qwm_fifo

// Sequencer: starts a burst once four beats wait in the buffer.
module qwm_ctrl #(
    parameter int LANES  = qwm_pkg::X36_LANES,
    parameter int LANE_W = qwm_pkg::BYTE_W,
    parameter int ADDR_W = qwm_pkg::ADDR_W,
    parameter int DEPTH  = qwm_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic                    clk_i,
    input  wire logic                    resetn_i,
    // One beat per accepted push; the address of each burst's first
    // beat is used, the other three addresses are ignored.
    input  wire logic                    req_valid_i,
    output logic                         req_ready_o,
    input  wire logic [ADDR_W-1:0]       req_addr_i,
    input  wire logic [LANES-1:0]        req_sel_n_i,
    input  wire logic [LANES*LANE_W-1:0] req_data_i,
    // High while a burst is on the link.
    output logic                         busy_o,
    // Link to the device.
    qwm_link_if.ctrl                     link
);
    localparam int DW = LANES * LANE_W;
    localparam int FW = ADDR_W + LANES + DW;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = qwm_pkg::PH_W;

    logic [FW-1:0]             head;
    logic                      head_valid;
    logic [CW-1:0]             level;
    logic                      pop;
    logic [PW-1:0]             ph;
    logic [PW-1:0]             next_ph;
    logic                      prep_k;
    logic                      prep_kn;
    qwm_pkg::qwm_ctl_state_t   state;
    logic [qwm_pkg::BEAT_W-1:0] beat;

    // The buffer stalls the user through req_ready_o when full.
    qwm_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (req_valid_i),
        .in_ready_o  (req_ready_o),
        .in_data_i   ({req_addr_i, req_sel_n_i, req_data_i}),
        .out_valid_o (head_valid),
        .out_ready_i (pop),
        .out_data_o  (head),
        .level_o     (level)
    );

    // Phase divider; link levels change one cycle before each rise.
    assign next_ph = PW'(ph + 1'b1);
    assign prep_k  = ph == qwm_pkg::PH_PREP_K;
    assign prep_kn = ph == qwm_pkg::PH_PREP_KN;
    assign pop = head_valid & (((state == qwm_pkg::CTL_ADDR) & prep_k) |
                 ((state == qwm_pkg::CTL_BEAT) & (prep_k | prep_kn)));

    // Two clocks, half a period apart; phase rests on its last slot so k's first high is full.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ph     <= '1;
            link.k  <= qwm_pkg::RST_CLK_LEVEL;
            link.kn <= qwm_pkg::RST_CLK_LEVEL;
        end else begin
            ph     <= next_ph;
            link.k  <= ~next_ph[PW-1];
            link.kn <= next_ph[PW-1];
        end
    end

    // Burst sequence. A new start waits until the previous burst has
    // sent its last beat, so starts never fall on consecutive rises.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state        <= qwm_pkg::CTL_IDLE;
            beat         <= '0;
            busy_o       <= 1'b0;
            link.start_n <= qwm_pkg::RST_START_N;
            link.addr    <= '0;
            link.lane_write_select_n <= '1;
            link.data    <= '0;
        end else if (prep_k | prep_kn) begin
            link.lane_write_select_n <= '1;
            case (state)
                qwm_pkg::CTL_IDLE: begin
                    if (prep_k && level >= CW'(qwm_pkg::BURST_LEN)) begin
                        link.start_n <= 1'b0;
                        link.addr    <= head[FW-1 -: ADDR_W];
                        state        <= qwm_pkg::CTL_ADDR;
                        busy_o       <= 1'b1;
                    end else begin
                        busy_o <= 1'b0;
                    end
                end
                qwm_pkg::CTL_ADDR: begin
                    if (prep_k) begin
                        link.start_n <= 1'b1;
                        link.lane_write_select_n <= head[DW +: LANES];
                        link.data    <= head[DW-1:0];
                        beat         <= 2'h1;
                        state        <= qwm_pkg::CTL_BEAT;
                    end
                end
                qwm_pkg::CTL_BEAT: begin
                    link.lane_write_select_n <= head[DW +: LANES];
                    link.data <= head[DW-1:0];
                    beat      <= beat + 2'h1;
                    if (beat == 2'h3) begin
                        state <= qwm_pkg::CTL_IDLE;
                    end
                end
                default: state <= qwm_pkg::CTL_IDLE;
            endcase
        end
    end
endmodule // qwm_ctrl

// ===== tb/qwm_chk.sv
// Concurrent checks on the controller-to-device link and on the device's beat reports.
// Assumes one clock domain; instantiated beside the link instance, connected by name.
module qwm_chk #(
    parameter int ADDR_W = qwm_pkg::ADDR_W,
    parameter int LANES  = qwm_pkg::X36_LANES
) (
    // Clock and reset.
    input wire logic              clk_i,
    input wire logic              resetn_i,
    // Link levels driven by the controller.
    input wire logic              k,
    input wire logic              kn,
    input wire logic              start_n,
    input wire logic [LANES-1:0]  lane_write_select_n,
    // Beat reports of the device.
    input wire logic              wr_strobe_o,
    input wire logic [ADDR_W-1:0] wr_addr_o,
    input wire logic [LANES-1:0]  wr_lane_en_o,
    input wire logic              ignored_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // All checks share the one clock, and each reset discards what was in flight.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // A start gives four beats, the first one input clock period later.
    a_burst_four_beats: assert property (
        $rose(k) && !start_n |-> ##[10:12] wr_strobe_o ##4 wr_strobe_o ##4 wr_strobe_o
        ##4 wr_strobe_o)
        else $error("burst did not yield four beats on time");
    // The negative clock rises half a period after the positive one.
    a_kn_follows_k: assert property ($rose(k) |-> ##4 $rose(kn))
        else $error("negative clock rise out of place");
    // The two input clocks are never high together.
    a_clocks_apart: assert property (!(k && kn))
        else $error("both input clocks high");
    // Beats inside one burst land on consecutive addresses.
    a_addr_steps: assert property (
        wr_strobe_o && $past(wr_strobe_o, 4) |->
        wr_addr_o == ADDR_W'($past(wr_addr_o, 4) + 1'b1))
        else $error("beat address not sequential");
    // Each lane enable is the inverse of that beat's own select.
    a_lane_en_sel: assert property (
        wr_strobe_o |-> wr_lane_en_o == ~$past(lane_write_select_n, 2))
        else $error("lane enable does not follow select");
    // The controller never starts on two consecutive positive clock rises.
    a_start_spacing: assert property ($rose(k) && !start_n |-> ##8 start_n)
        else $error("write start on consecutive rises");
    // With a well-behaved controller nothing is ever refused.
    a_never_ignored: assert property (!ignored_o)
        else $error("device refused a legal start");
    // Beats come at most once every four cycles.
    a_strobe_gap: assert property (wr_strobe_o |=> (!wr_strobe_o)[*3])
        else $error("beats closer than half a period");
    // During the address phase the selects rest high.
    a_idle_sel_high: assert property (!start_n |-> &lane_write_select_n)
        else $error("selects low during address phase");

    // Main scenarios reached.
    c_start: cover property ($rose(k) && !start_n);
    c_masked_beat: cover property (wr_strobe_o && wr_lane_en_o == '0);
    c_partial_beat: cover property (wr_strobe_o && wr_lane_en_o != '0 && !(&wr_lane_en_o));
endmodule // qwm_chk

// ===== tb/qwm_write_byte_lane_mask_tb.sv
// Self-checking bench: controller and device joined by one link, plus an eight-bit
// device driven by the bench for nibble masks and a refused back-to-back start.
// Assumes the package, interface and design modules are compiled before it.
module qwm_write_byte_lane_mask_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [5:0] addr; logic [15:0] sel;} qwm_row_t;
    // Clock, reset and user side of the controller.
    logic        clk_i;
    logic        resetn_i;
    logic        req_valid_i;
    logic        req_ready_o;
    logic [5:0]  req_addr_i;
    logic [3:0]  req_sel_n_i;
    logic [35:0] req_data_i;
    logic        busy_o;
    // Device observation.
    logic [5:0]  rd_addr;
    logic [35:0] rd36;
    logic [7:0]  rd8;
    logic        str1, str2, ign1, ign2;
    logic [5:0]  wa1;
    logic [3:0]  le1;
    int          n_errors, tests_run, n_str1, n_str2, n_ign2;
    logic [35:0] exp36 [64];
    logic [7:0]  exp8 [64];
    bit          saw_full;
    // Each row is one burst: base address and four beats of selects, beat 0 lowest.
    qwm_row_t    rows [6] = '{'{6'h00, 16'h0000}, '{6'h00, 16'h7BDE}, '{6'h3E, 16'h0000},
                              '{6'h3E, 16'hF0F5}, '{6'h10, 16'h0000}, '{6'h10, 16'hFFFF}};

    qwm_link_if link1 ();
    qwm_link_if #(.LANES(2), .LANE_W(4)) link2 ();
    qwm_ctrl qwm_ctrl_inst (.clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_addr_i(req_addr_i), .req_sel_n_i(req_sel_n_i),
        .req_data_i(req_data_i), .busy_o(busy_o), .link(link1));
    qwm_device qwm_device_inst (.clk_i(clk_i), .resetn_i(resetn_i), .link(link1),
        .rd_addr_i(rd_addr), .rd_data_o(rd36), .wr_strobe_o(str1), .wr_addr_o(wa1),
        .wr_lane_en_o(le1), .wr_data_o(), .ignored_o(ign1));
    qwm_device #(.LANES(2), .LANE_W(4)) qwm_device_x8_inst (.clk_i(clk_i),
        .resetn_i(resetn_i), .link(link2), .rd_addr_i(rd_addr), .rd_data_o(rd8),
        .wr_strobe_o(str2), .wr_addr_o(), .wr_lane_en_o(), .wr_data_o(), .ignored_o(ign2));
    qwm_chk qwm_chk_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .k(link1.k), .kn(link1.kn), .start_n(link1.start_n),
        .lane_write_select_n(link1.lane_write_select_n), .wr_strobe_o(str1),
        .wr_addr_o(wa1), .wr_lane_en_o(le1), .ignored_o(ign1));

    // Free-running system clock.
    initial begin
        clk_i = 1'b0;
        forever #(qwm_pkg::CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    end

    // Beat and refusal pulses are counted so that none can slip by unseen.
    always @(posedge clk_i) begin
        n_str1 += int'(str1 === 1'b1);
        n_str2 += int'(str2 === 1'b1);
        n_ign2 += int'(ign2 === 1'b1);
    end

    // Beat data with distinct lanes except in bd(0, 0) and bd(0, 1), where lane 3 equals lane 0.
    function automatic logic [35:0] bd(input int r, input int b);
        return 36'(36'h9ABCDE135 * (r * 4 + b + 1));
    endfunction

    task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({35'h0, got}, {35'h0, exp});
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Offers one beat and holds it until the buffer takes it on a rising edge.
    task automatic push(input logic [5:0] a, input logic [3:0] s, input logic [35:0] d);
        req_valid_i = 1'b1;
        req_addr_i = a;
        req_sel_n_i = s;
        req_data_i = d;
        while (req_ready_o !== 1'b1) begin
            saw_full = 1'b1;
            @(negedge clk_i);
        end
        @(negedge clk_i);
    endtask

    // Waits until the controller has stayed idle long enough for the last burst to land.
    task automatic wait_idle();
        int idle, i;
        idle = 0;
        for (i = 0; i < 1000 && idle < 16; i++) begin
            @(negedge clk_i);
            idle = (busy_o === 1'b0) ? idle + 1 : 0;
        end
        chk_bit(idle >= 16, 1'b1);
    endtask

    // Reads back one location; the read path needs one edge to settle.
    task automatic rd_check(input bit x8, input logic [5:0] a);
        rd_addr = a;
        repeat (3) @(negedge clk_i);
        if (x8) chk_word({28'h0000000, rd8}, {28'h0000000, exp8[a]});
        else chk_word(rd36, exp36[a]);
    endtask

    // One half period of the bench-driven link; data settles a cycle before the rise.
    task automatic half(input bit on_k, input logic sn, input logic [5:0] a,
                        input logic [1:0] s, input logic [7:0] d);
        link2.start_n = sn;
        link2.addr = a;
        link2.lane_write_select_n = s;
        link2.data = d;
        @(negedge clk_i);
        link2.k = on_k;
        link2.kn = ~on_k;
        repeat (3) @(negedge clk_i);
    endtask

    // Burst on the eight-bit link; retry repeats the start on beat 0's rise.
    task automatic burst8(input logic [5:0] a, input logic [7:0] s, input logic [31:0] d,
                          input bit retry);
        int b;
        half(1'b1, 1'b0, a, 2'h3, 8'hA5);
        half(1'b0, 1'b1, a, 2'h3, 8'h5A);
        for (b = 0; b < 4; b++) begin
            half(b % 2 == 0, !(retry && b == 0), a + 6'h08, s[b*2+:2], d[b*8+:8]);
            if (!s[b*2]) exp8[6'(a + b)][3:0] = d[b*8+:4];
            if (!s[b*2+1]) exp8[6'(a + b)][7:4] = d[b*8+4+:4];
        end
        half(1'b1, 1'b1, 6'h00, 2'h3, 8'h00);
        half(1'b0, 1'b1, 6'h00, 2'h3, 8'h00);
    endtask

    // A hang ends the run through the same closing task.
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        final_report();
    end

    initial begin
        int r, b, l;
        logic [3:0]  s;
        logic [35:0] d;
        {n_errors, tests_run, n_str1, n_str2, n_ign2} = '0;
        saw_full = 1'b0;
        resetn_i = 1'b0;
        req_valid_i = 1'b0;
        req_addr_i = '0;
        req_sel_n_i = '1;
        req_data_i = '0;
        rd_addr = '0;
        link2.k = 1'b0;
        link2.kn = 1'b0;
        link2.start_n = 1'b1;
        link2.addr = '0;
        link2.lane_write_select_n = '1;
        link2.data = '0;
        foreach (exp36[i]) exp36[i] = 'x;
        foreach (exp8[i]) exp8[i] = 'x;
        repeat (8) @(negedge clk_i);
        resetn_i = 1'b1;
        @(negedge clk_i);
        // All rows are pushed back to back, so the buffer also fills and refuses.
        for (r = 0; r < 6; r++) begin
            for (b = 0; b < 4; b++) begin
                s = rows[r].sel[b*4+:4];
                d = bd(r, b);
                push(rows[r].addr, s, d);
                for (l = 0; l < 4; l++)
                    if (!s[l]) exp36[6'(rows[r].addr + b)][l*9+:9] = d[l*9+:9];
            end
        end
        req_valid_i = 1'b0;
        wait_idle();
        for (r = 0; r < 6; r++)
            for (b = 0; b < 4; b++)
                rd_check(1'b0, 6'(rows[r].addr + b));
        chk_bit(saw_full, 1'b1);
        chk_word(36'(n_str1), 36'h000000018);
        // Eight-bit link: full write, then per-beat nibble masks with a repeated start.
        burst8(6'h05, 8'h00, 32'h87654321, 1'b0);
        burst8(6'h05, 8'h36, 32'hFEDCBA98, 1'b1);
        for (b = 0; b < 4; b++)
            rd_check(1'b1, 6'(5 + b));
        rd_check(1'b1, 6'h0D);
        chk_word(36'(n_ign2), 36'h000000001);
        chk_word(36'(n_str2), 36'h000000008);
        // Reset in mid-burst returns the link and the reports to rest.
        for (b = 0; b < 4; b++)
            push(6'h20, 4'h0, bd(7, b));
        req_valid_i = 1'b0;
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b0;
        @(negedge clk_i);
        chk_bit(busy_o, 1'b0);
        chk_bit(req_ready_o, 1'b1);
        chk_bit(link1.start_n, 1'b1);
        chk_bit(link1.k, 1'b0);
        chk_bit(str1, 1'b0);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        final_report();
    end
endmodule // qwm_write_byte_lane_mask_tb
